// ==== emx_pkg.sv ====
// Constants and types shared by the multiplier slice, the fabric model and the bench.
// Assumes every user writes emx_pkg::name; nothing is imported.
package emx_pkg;

    // ------------------------------------------------------------
    // Datapath widths
    // ------------------------------------------------------------
    localparam int WIDE_W = 18;
    localparam int NARROW_W = 9;
    localparam int PROD_W = 36;
    localparam int HALF_PROD_W = 18;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HI_W = PROD_W - DATA_W;
    localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] RESLO_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RESHI_OFS = 8'h08;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int CFG_W = 7;
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_REGA_BIT = 1;
    localparam int CFG_REGB_BIT = 2;
    localparam int CFG_REGSA_BIT = 3;
    localparam int CFG_REGSB_BIT = 4;
    localparam int CFG_REGOUT_BIT = 5;
    localparam int CFG_SIGNEN_BIT = 6;
    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        EMX_MODE_WIDE,
        EMX_MODE_DUAL
    } emx_mode_t;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [DATA_W-1:0] rdata;
    } emx_state_t;

    localparam emx_state_t STATE_RST = '{cfg: CFG_RST, rdata: RDATA_RST};

endpackage

// ==== emx_pipe_sec.sv ====
// One bypassable register section of the slice.
// Assumes the shared clock, enable and clear of the slice drive it.
`timescale 1ns/1ps
module emx_pipe_sec #(
    parameter int W = 9
) (
    // Common controls
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Section
    input wire logic useReg,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] data;
    } emx_sec_t;

    emx_sec_t st_ff;
    emx_sec_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clkEn) begin
            nxt_st.data = d;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bypass is pure wiring, so a bypassed section adds no latency
    assign q = useReg ? st_ff.data : d;

endmodule // emx_pipe_sec

// ==== emx_mul.sv ====
// Full-precision multiplier core with per-operand sign selection.
// Assumes operands arrive already registered or bypassed.
`timescale 1ns/1ps
module emx_mul #(
    parameter int W = 9
) (
    // Operands
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic aSigned,
    input wire logic bSigned,
    // Product
    output logic [2*W-1:0] p
);

    logic signed [W:0] aExt;
    logic signed [W:0] bExt;
    logic signed [2*W+1:0] full;

    // One extra bit carries the sign, so unsigned and signed share one array
    assign aExt = {aSigned & a[W-1], a};
    assign bExt = {bSigned & b[W-1], b};
    assign full = aExt * bExt;
    // Any mix of signs fits in 2W bits, so the cut loses nothing
    assign p = full[2*W-1:0];

endmodule // emx_mul

// ==== emx_mult_slice.sv ====
// Embedded hard multiplier slice: one 18x18 or two 9x9 products.
// Assumes fabric logic on ref_clk drives operands, signs and the register port.
//
// Contract
// RULE1: One 18x18 or two 9x9 multipliers.
// RULE2: Operands enter in 9- or 18-bit sections.
// RULE3: Register or bypass chosen per operand.
// RULE4: One clock, enable, clear for all registers.
// RULE5: Sign select high means signed operand.
// RULE6: Product signed if any operand signed.
// RULE7: Exactly one sign select per operand.
// RULE8: Sign selects may change at run time.
// RULE9: Optional dedicated register per sign select.
// RULE10: Full precision, no truncation or saturation.
// RULE11: Optional output registers in 18/36-bit sections.
// RULE12: One or two products every cycle.
// RULE13: Smaller widths placed in mode sections.
// RULE14: Unused sign selects mean unsigned multiply.
// RULE15: Dual mode shares one sign per operand.
// RULE16: Wide mode 10-18 bits, dual up to 9.
// RULE17: Load on enable, async clear zeros all.
// RULE18: Dual products fill independent 18-bit sections.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module emx_mult_slice (
    // Clock, enable and common clear
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Register port
    input wire logic [emx_pkg::ADDR_W-1:0] regAddr,
    input wire logic [emx_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [emx_pkg::DATA_W-1:0] regRdata,
    // Operands and sign selects from fabric
    input wire logic [emx_pkg::WIDE_W-1:0] dataA,
    input wire logic [emx_pkg::WIDE_W-1:0] dataB,
    input wire logic signA,
    input wire logic signB,
    // Product
    output logic [emx_pkg::PROD_W-1:0] result,
    output logic resultSigned
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    emx_pkg::emx_state_t st_ff;
    emx_pkg::emx_state_t nxt_state;

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    emx_pkg::emx_mode_t modeSel;
    logic modeDual;
    logic regA;
    logic regB;
    logic regSa;
    logic regSb;
    logic regOut;
    logic signEn;

    assign modeDual = st_ff.cfg[emx_pkg::CFG_MODE_BIT];
    assign regA = st_ff.cfg[emx_pkg::CFG_REGA_BIT];
    assign regB = st_ff.cfg[emx_pkg::CFG_REGB_BIT];
    assign regSa = st_ff.cfg[emx_pkg::CFG_REGSA_BIT];
    assign regSb = st_ff.cfg[emx_pkg::CFG_REGSB_BIT];
    assign regOut = st_ff.cfg[emx_pkg::CFG_REGOUT_BIT];
    assign signEn = st_ff.cfg[emx_pkg::CFG_SIGNEN_BIT];
    assign modeSel = modeDual ? emx_pkg::EMX_MODE_DUAL : emx_pkg::EMX_MODE_WIDE; // see RULE1

    // ------------------------------------------------------------
    // Sign selects
    // ------------------------------------------------------------
    logic saIn;
    logic sbIn;
    logic saQ;
    logic sbQ;

    // Signs are ignored until software enables them, so reset is unsigned
    assign saIn = signEn & signA; // see RULE14
    assign sbIn = signEn & signB; // see RULE7

    // Live sign pins feed the core every cycle, no reconfiguration needed
    emx_pipe_sec #(.W(1)) u_signA ( // see RULE9
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regSa),
        .d(saIn),
        .q(saQ)
    ); // see RULE8
    emx_pipe_sec #(.W(1)) u_signB ( // see RULE9
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regSb),
        .d(sbIn),
        .q(sbQ)
    );

    // ------------------------------------------------------------
    // Operand input sections
    // ------------------------------------------------------------
    logic [emx_pkg::NARROW_W-1:0] aLoQ;
    logic [emx_pkg::NARROW_W-1:0] aHiQ;
    logic [emx_pkg::NARROW_W-1:0] bLoQ;
    logic [emx_pkg::NARROW_W-1:0] bHiQ;

    // Both halves of one operand share its register choice
    emx_pipe_sec #(.W(emx_pkg::NARROW_W)) u_aLo ( // see RULE2
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regA),
        .d(dataA[emx_pkg::NARROW_W-1:0]),
        .q(aLoQ)
    ); // see RULE3
    emx_pipe_sec #(.W(emx_pkg::NARROW_W)) u_aHi (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regA),
        .d(dataA[emx_pkg::WIDE_W-1:emx_pkg::NARROW_W]),
        .q(aHiQ)
    );
    emx_pipe_sec #(.W(emx_pkg::NARROW_W)) u_bLo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regB),
        .d(dataB[emx_pkg::NARROW_W-1:0]),
        .q(bLoQ)
    ); // see RULE3
    emx_pipe_sec #(.W(emx_pkg::NARROW_W)) u_bHi (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regB),
        .d(dataB[emx_pkg::WIDE_W-1:emx_pkg::NARROW_W]),
        .q(bHiQ)
    );

    // ------------------------------------------------------------
    // Multiplier stage
    // ------------------------------------------------------------
    logic [emx_pkg::PROD_W-1:0] pWide;
    logic [emx_pkg::HALF_PROD_W-1:0] pLo;
    logic [emx_pkg::HALF_PROD_W-1:0] pHi;
    logic [emx_pkg::PROD_W-1:0] prodMux;
    logic prodSigned;

    emx_mul #(.W(emx_pkg::WIDE_W)) u_mulWide ( // see RULE10
        .a({aHiQ, aLoQ}),
        .b({bHiQ, bLoQ}),
        .aSigned(saQ),
        .bSigned(sbQ),
        .p(pWide)
    ); // see RULE5
    // One sign per operand drives both narrow cores
    emx_mul #(.W(emx_pkg::NARROW_W)) u_mulLo (
        .a(aLoQ),
        .b(bLoQ),
        .aSigned(saQ),
        .bSigned(sbQ),
        .p(pLo)
    ); // see RULE15
    emx_mul #(.W(emx_pkg::NARROW_W)) u_mulHi (
        .a(aHiQ),
        .b(bHiQ),
        .aSigned(saQ),
        .bSigned(sbQ),
        .p(pHi)
    ); // see RULE18

    // Narrow widths go in the low section bits; wide mode covers 10 to 18
    always_comb begin // see RULE13
        case (modeSel)
            emx_pkg::EMX_MODE_DUAL: prodMux = {pHi, pLo}; // see RULE12
            default: prodMux = pWide; // see RULE16
        endcase
    end

    assign prodSigned = saQ | sbQ; // see RULE6

    // ------------------------------------------------------------
    // Output sections
    // ------------------------------------------------------------
    emx_pipe_sec #(.W(emx_pkg::HALF_PROD_W)) u_outLo ( // see RULE11
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regOut),
        .d(prodMux[emx_pkg::HALF_PROD_W-1:0]),
        .q(result[emx_pkg::HALF_PROD_W-1:0])
    );
    emx_pipe_sec #(.W(emx_pkg::HALF_PROD_W)) u_outHi (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regOut),
        .d(prodMux[emx_pkg::PROD_W-1:emx_pkg::HALF_PROD_W]),
        .q(result[emx_pkg::PROD_W-1:emx_pkg::HALF_PROD_W])
    );
    emx_pipe_sec #(.W(1)) u_outSgn (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .useReg(regOut),
        .d(prodSigned),
        .q(resultSigned)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = st_ff;
        if (clkEn) begin // see RULE17
            nxt_state.rdata = emx_pkg::RDATA_RST;
            if (regWr && regAddr == emx_pkg::CFG_OFS) begin
                nxt_state.cfg = regWdata[emx_pkg::CFG_W-1:0];
            end
            if (regRd) begin
                case (regAddr)
                    emx_pkg::CFG_OFS: begin
                        nxt_state.rdata = {{(emx_pkg::DATA_W - emx_pkg::CFG_W){1'b0}},
                                           st_ff.cfg};
                    end
                    emx_pkg::RESLO_OFS: nxt_state.rdata = result[emx_pkg::DATA_W-1:0];
                    emx_pkg::RESHI_OFS: begin
                        nxt_state.rdata = {{(emx_pkg::DATA_W - emx_pkg::HI_W - 1){1'b0}},
                                           resultSigned,
                                           result[emx_pkg::PROD_W-1:emx_pkg::DATA_W]};
                    end
                    default: nxt_state.rdata = emx_pkg::RDATA_RST;
                endcase
            end
        end
    end

    // Same clock and clear as every section register
    always_ff @(posedge ref_clk or negedge reset_n) begin // see RULE4
        if (!reset_n) begin
            st_ff <= emx_pkg::STATE_RST;
        end else begin
            st_ff <= nxt_state;
        end
    end

    assign regRdata = st_ff.rdata;

    // ------------------------------------------------------------
    // Reference products for checking
    // ------------------------------------------------------------
    logic signed [emx_pkg::WIDE_W:0] refA18;
    logic signed [emx_pkg::WIDE_W:0] refB18;
    logic signed [2*emx_pkg::WIDE_W+1:0] refP18;
    logic [emx_pkg::PROD_W-1:0] refWide;
    logic signed [emx_pkg::NARROW_W:0] refALo;
    logic signed [emx_pkg::NARROW_W:0] refBLo;
    logic signed [emx_pkg::NARROW_W:0] refAHi;
    logic signed [emx_pkg::NARROW_W:0] refBHi;
    logic signed [2*emx_pkg::NARROW_W+1:0] refPLo;
    logic signed [2*emx_pkg::NARROW_W+1:0] refPHi;
    logic allBypass;
    logic allReg;
    logic [emx_pkg::CFG_W-1:0] cfgWrVal;

    assign refA18 = {saIn & dataA[emx_pkg::WIDE_W-1], dataA};
    assign refB18 = {sbIn & dataB[emx_pkg::WIDE_W-1], dataB};
    assign refP18 = refA18 * refB18;
    assign refWide = refP18[emx_pkg::PROD_W-1:0];
    assign refALo = {saIn & dataA[emx_pkg::NARROW_W-1], dataA[emx_pkg::NARROW_W-1:0]};
    assign refBLo = {sbIn & dataB[emx_pkg::NARROW_W-1], dataB[emx_pkg::NARROW_W-1:0]};
    assign refAHi = {saIn & dataA[emx_pkg::WIDE_W-1], dataA[emx_pkg::WIDE_W-1:emx_pkg::NARROW_W]};
    assign refBHi = {sbIn & dataB[emx_pkg::WIDE_W-1], dataB[emx_pkg::WIDE_W-1:emx_pkg::NARROW_W]};
    assign refPLo = refALo * refBLo;
    assign refPHi = refAHi * refBHi;
    assign allBypass = !regA && !regB && !regSa && !regSb && !regOut;
    assign allReg = regA && regB && regSa && regSb && regOut;
    assign cfgWrVal = regWdata[emx_pkg::CFG_W-1:0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_wide_comb;
        @(posedge ref_clk) disable iff (!reset_n)
        (allBypass && !modeDual) |-> (result == refWide);
    endproperty
    a_wide_comb: assert property (p_wide_comb) // see RULE10
        else $error("wide product differs from full-precision reference");
    property p_dual_lo;
        @(posedge ref_clk) disable iff (!reset_n)
        (allBypass && modeDual) |->
            (result[emx_pkg::HALF_PROD_W-1:0] == refPLo[emx_pkg::HALF_PROD_W-1:0]);
    endproperty
    a_dual_lo: assert property (p_dual_lo) // see RULE18
        else $error("low narrow product wrong");
    property p_dual_hi;
        @(posedge ref_clk) disable iff (!reset_n)
        (allBypass && modeDual) |->
            (result[emx_pkg::PROD_W-1:emx_pkg::HALF_PROD_W]
             == refPHi[emx_pkg::HALF_PROD_W-1:0]);
    endproperty
    a_dual_hi: assert property (p_dual_hi) // see RULE15
        else $error("high narrow product wrong");
    property p_sign_flag;
        @(posedge ref_clk) disable iff (!reset_n)
        allBypass |-> (resultSigned == (saIn || sbIn));
    endproperty
    a_sign_flag: assert property (p_sign_flag) // see RULE6
        else $error("result sign flag wrong");
    property p_unsigned_def;
        @(posedge ref_clk) disable iff (!reset_n)
        (!signEn && !regSa && !regSb && !regOut) |-> !resultSigned;
    endproperty
    a_unsigned_def: assert property (p_unsigned_def) // see RULE14
        else $error("sign used while sign selects disabled");
    property p_sign_dyn;
        @(posedge ref_clk) disable iff (!reset_n)
        (allBypass && signEn && $changed(signA)) |-> (resultSigned == (signA || sbIn));
    endproperty
    a_sign_dyn: assert property (p_sign_dyn) // see RULE8
        else $error("sign change not applied at once");
    property p_in_reg;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && regA && regB && regSa && regSb && !regOut && !modeDual
         && !regWr) |=> (result == $past(refWide));
    endproperty
    a_in_reg: assert property (p_in_reg) // see RULE3
        else $error("registered inputs not one cycle late");
    property p_two_stage;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && allReg && !modeDual && !regWr) ##1 (clkEn && !regWr)
            |=> (result == $past(refWide, 2));
    endproperty
    a_two_stage: assert property (p_two_stage) // see RULE11
        else $error("fully registered product not two cycles late");
    property p_freeze;
        @(posedge ref_clk) disable iff (!reset_n)
        (!clkEn && allReg) |=> ($stable(result) && $stable(regRdata));
    endproperty
    a_freeze: assert property (p_freeze) // see RULE17
        else $error("state moved while clock enable low");
    property p_cfg_wr;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && regWr && regAddr == emx_pkg::CFG_OFS) |=> (st_ff.cfg == $past(cfgWrVal));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) // see RULE4
        else $error("configuration write lost");
    property p_rd_slot;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && !regRd) |=> (regRdata == emx_pkg::RDATA_RST);
    endproperty
    a_rd_slot: assert property (p_rd_slot) // see RULE17
        else $error("read data outside its slot");
    property p_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(reset_n) |-> (regRdata == emx_pkg::RDATA_RST && st_ff.cfg == emx_pkg::CFG_RST);
    endproperty
    a_clear: assert property (p_clear) // see RULE17
        else $error("clear did not zero registers");

endmodule // emx_mult_slice

// ==== emx_fabric_model.sv ====
// Fabric-side model that feeds operands and sign selects to the slice.
// Assumes the bench calls put() and shares ref_clk with the slice.
`timescale 1ns/1ps
module emx_fabric_model (
    // Clock
    input wire logic ref_clk,
    // Operands and sign selects towards the slice
    output logic [emx_pkg::WIDE_W-1:0] dataA,
    output logic [emx_pkg::WIDE_W-1:0] dataB,
    output logic signA,
    output logic signB
);
    // ------------------------------------------------------------
    // Drive
    // ------------------------------------------------------------
    initial begin
        dataA = 18'h00000;
        dataB = 18'h00000;
        signA = 1'b0;
        signB = 1'b0;
    end

    // Fabric logic holds its outputs; new values land just after an edge
    task automatic put(input logic [17:0] a, input logic [17:0] b, input logic sa,
                       input logic sb);
        @(posedge ref_clk);
        dataA <= a;
        dataB <= b;
        signA <= sa;
        signB <= sb;
    endtask
endmodule // emx_fabric_model

// ==== emx_mult_slice_test.sv ====
// Self-checking bench for the multiplier slice.
// Assumes the fabric model drives operands; registers reached by strobes.
`timescale 1ns/1ps
module emx_mult_slice_test;
    logic ref_clk;
    logic reset_n;
    logic clkEn;
    logic [emx_pkg::ADDR_W-1:0] regAddr;
    logic [emx_pkg::DATA_W-1:0] regWdata;
    logic regWr;
    logic regRd;
    logic [emx_pkg::DATA_W-1:0] regRdata;
    logic [emx_pkg::WIDE_W-1:0] dataA;
    logic [emx_pkg::WIDE_W-1:0] dataB;
    logic signA;
    logic signB;
    logic [emx_pkg::PROD_W-1:0] result;
    logic resultSigned;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    emx_fabric_model fab (.ref_clk(ref_clk), .dataA(dataA), .dataB(dataB),
                          .signA(signA), .signB(signB));
    emx_mult_slice DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
                        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
                        .regRd(regRd), .regRdata(regRdata), .dataA(dataA), .dataB(dataB),
                        .signA(signA), .signB(signB), .result(result),
                        .resultSigned(resultSigned));

    // ------------------------------------------------------------
    // Clock, reset, timeout
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // The whole run needs under a hundred cycles; 5000 catches a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    // Reference product of w-bit operands, two's complement where selected
    function automatic logic [35:0] xmul(logic [17:0] a, logic [17:0] b, logic sa,
                                         logic sb, int w);
        longint va;
        longint vb;
        longint p;
        logic [35:0] r;
        va = a;
        vb = b;
        if (sa && a[w-1]) va -= (64'sh1 << w);
        if (sb && b[w-1]) vb -= (64'sh1 << w);
        p = va * vb;
        r = p[35:0];
        if (w == 9) r[35:18] = 18'h00000;
        return r;
    endfunction

    function automatic logic [35:0] dmul(logic [17:0] a, logic [17:0] b, logic sa, logic sb);
        logic [35:0] lo;
        logic [35:0] hi;
        lo = xmul({9'h000, a[8:0]}, {9'h000, b[8:0]}, sa, sb, 9);
        hi = xmul({9'h000, a[17:9]}, {9'h000, b[17:9]}, sa, sb, 9);
        return {hi[17:0], lo[17:0]};
    endfunction

    function automatic logic [31:0] cfgw(logic md, logic ra, logic rb, logic rsa, logic rsb,
                                         logic ro, logic se);
        return (32'(md) << emx_pkg::CFG_MODE_BIT) | (32'(ra) << emx_pkg::CFG_REGA_BIT)
             | (32'(rb) << emx_pkg::CFG_REGB_BIT) | (32'(rsa) << emx_pkg::CFG_REGSA_BIT)
             | (32'(rsb) << emx_pkg::CFG_REGSB_BIT) | (32'(ro) << emx_pkg::CFG_REGOUT_BIT)
             | (32'(se) << emx_pkg::CFG_SIGNEN_BIT);
    endfunction

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= addr;
        regWdata <= data;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= addr;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        check({4'h0, exp}, {4'h0, regRdata});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        reg_read(emx_pkg::CFG_OFS, 32'h0000_0000);
        @(negedge ref_clk);
        check(36'h0, {4'h0, regRdata});
        reg_read(8'h0c, 32'h0000_0000);
        reg_write(emx_pkg::RESLO_OFS, 32'hffff_ffff);
        reg_read(emx_pkg::CFG_OFS, 32'h0000_0000);
        fab.put(18'h3ffff, 18'h3ffff, 1'b1, 1'b1);
        @(negedge ref_clk);
        check(xmul(18'h3ffff, 18'h3ffff, 1'b0, 1'b0, 18), result);
        $display("test defaults done");
    endtask

    task automatic t_wide_signs();
        logic sa;
        logic sb;
        logic [35:0] e;
        reg_write(emx_pkg::CFG_OFS, cfgw(0, 0, 0, 0, 0, 0, 1));
        for (int i = 0; i < 4; i++) begin
            sa = i[1];
            sb = i[0];
            e = xmul(18'h20001, 18'h3fffe, sa, sb, 18);
            fab.put(18'h20001, 18'h3fffe, sa, sb);
            @(negedge ref_clk);
            check(e, result);
            check({35'h0, sa | sb}, {35'h0, resultSigned});
            reg_read(emx_pkg::RESLO_OFS, e[31:0]);
            reg_read(emx_pkg::RESHI_OFS, {27'h0, sa | sb, e[35:32]});
        end
        $display("test wide signs done");
    endtask

    task automatic t_dual();
        logic sa;
        logic sb;
        reg_write(emx_pkg::CFG_OFS, cfgw(1, 0, 0, 0, 0, 0, 1));
        for (int i = 0; i < 4; i++) begin
            sa = i[1];
            sb = i[0];
            fab.put({9'h100, 9'h0ff}, {9'h1ff, 9'h101}, sa, sb);
            @(negedge ref_clk);
            check(dmul({9'h100, 9'h0ff}, {9'h1ff, 9'h101}, sa, sb), result);
        end
        // Small operands zero-filled into the high section, full-scale 9-bit ones in the low
        fab.put({9'h005, 9'h1ff}, {9'h003, 9'h1ff}, 1'b0, 1'b0);
        @(negedge ref_clk);
        check(dmul({9'h005, 9'h1ff}, {9'h003, 9'h1ff}, 1'b0, 1'b0), result);
        $display("test dual done");
    endtask

    task automatic t_per_operand();
        reg_write(emx_pkg::CFG_OFS, cfgw(0, 1, 0, 0, 0, 0, 0));
        fab.put(18'h00123, 18'h00456, 1'b0, 1'b0);
        fab.put(18'h3ff00, 18'h00789, 1'b0, 1'b0);
        @(negedge ref_clk);
        check(xmul(18'h00123, 18'h00789, 0, 0, 18), result);
        reg_write(emx_pkg::CFG_OFS, cfgw(0, 0, 1, 0, 0, 0, 0));
        fab.put(18'h00011, 18'h00022, 1'b0, 1'b0);
        fab.put(18'h00033, 18'h00044, 1'b0, 1'b0);
        @(negedge ref_clk);
        check(xmul(18'h00033, 18'h00022, 0, 0, 18), result);
        // Inputs and signs registered, output bypassed: one cycle late
        reg_write(emx_pkg::CFG_OFS, cfgw(0, 1, 1, 1, 1, 0, 1));
        fab.put(18'h3fffd, 18'h00007, 1'b1, 1'b0);
        fab.put(18'h00001, 18'h00001, 1'b0, 1'b0);
        @(negedge ref_clk);
        check(xmul(18'h3fffd, 18'h00007, 1, 0, 18), result);
        check(36'h1, {35'h0, resultSigned});
        $display("test per operand done");
    endtask

    task automatic t_pipeline();
        logic [31:0] c;
        c = cfgw(0, 1, 1, 1, 1, 1, 1);
        reg_write(emx_pkg::CFG_OFS, c);
        fab.put(18'h30000, 18'h00005, 1'b1, 1'b0);
        fab.put(18'h30000, 18'h00005, 1'b0, 1'b0);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(xmul(18'h30000, 18'h00005, 1, 0, 18), result);
        check(36'h1, {35'h0, resultSigned});
        @(negedge ref_clk);
        check(xmul(18'h30000, 18'h00005, 0, 0, 18), result);
        check(36'h0, {35'h0, resultSigned});
        // Enable low: nothing loads, register writes ignored
        @(posedge ref_clk);
        clkEn <= 1'b0;
        fab.put(18'h3ffff, 18'h00002, 1'b1, 1'b1);
        reg_write(emx_pkg::CFG_OFS, 32'h0000_0000);
        @(negedge ref_clk);
        check(xmul(18'h30000, 18'h00005, 0, 0, 18), result);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check(xmul(18'h3ffff, 18'h00002, 1, 1, 18), result);
        reg_read(emx_pkg::CFG_OFS, c);
        // Clear in mid-run: it acts at once, not at the next edge
        @(posedge ref_clk);
        reset_n <= 1'b0;
        #1;
        check(xmul(18'h3ffff, 18'h00002, 0, 0, 18), result);
        check(36'h0, {35'h0, resultSigned});
        @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(emx_pkg::CFG_OFS, 32'h0000_0000);
        $display("test pipeline done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_defaults();
        t_wide_signs();
        t_dual();
        t_per_operand();
        t_pipeline();
        final_report();
    end
endmodule // emx_mult_slice_test
